/* File: ssx_alu.sv */
// Purpose: Shared constants and types, and the flag-computing arithmetic
//          and logic unit for the subtract, swap and exclusive-OR group.
// Assumes: Purely combinational unit; the caller routes the result.
// Notes:   Borrow is carried as an active-low carry, so one adder
//          serves both subtract forms.
`default_nettype none

package ssx_pkg;
   // ************************************************************
   // Register map (byte addresses, one word each)
   // ************************************************************
   localparam logic [7:0] ADDR_ACC   = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_FADDR = 8'h08;
   localparam logic [7:0] ADDR_FDATA = 8'h0c;
   localparam logic [7:0] ADDR_INSTR = 8'h10;
   localparam logic [7:0] ADDR_DIR_A = 8'h14;
   localparam logic [7:0] ADDR_DIR_B = 8'h18;
   localparam logic [7:0] ADDR_DIR_C = 8'h1c;

   // ************************************************************
   // Field layouts and reset values
   // ************************************************************
   localparam int          FLAG_C      = 0;
   localparam int          FLAG_DC     = 1;
   localparam int          FLAG_Z      = 2;
   localparam int          OP_LSB      = 0;
   localparam int          DST_BIT     = 3;
   localparam int          OPND_LSB    = 8;
   localparam int          FILE_DEPTH  = 128;
   localparam logic [6:0]  DIR_OPND_A  = 7'h05;
   localparam logic [6:0]  DIR_OPND_B  = 7'h06;
   localparam logic [6:0]  DIR_OPND_C  = 7'h07;
   localparam logic [7:0]  DIR_RESET   = 8'hff;
   localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

   typedef enum logic [2:0] {
      SUB_ACC_FROM_FILE,
      SUB_ACC_FROM_FILE_BORROW,
      NIBBLE_EXCHANGE,
      DIRECTION_LOAD,
      XOR_IMMEDIATE,
      XOR_FILE
   } ssx_op_t;

   typedef struct packed {
      ssx_op_t    op;
      logic [7:0] acc;
      logic [7:0] fval;
      logic [7:0] lit;
      logic       cin;
   } ssx_alu_in_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dc;
      logic       z;
      logic       wr_c;
      logic       wr_dc;
      logic       wr_z;
   } ssx_alu_out_t;

   // Operations that take a file operand and honour the destination bit
   function automatic logic ssx_is_file_op(input ssx_op_t op);
      ssx_is_file_op = (op == SUB_ACC_FROM_FILE) || (op == SUB_ACC_FROM_FILE_BORROW) ||
                       (op == NIBBLE_EXCHANGE) || (op == XOR_FILE);
   endfunction
endpackage

module ssx_alu
   import ssx_pkg::*;
(
   input  wire ssx_alu_in_t  ain,  // Operation and operands
   output var  ssx_alu_out_t aout  // Result and flag updates
);
   // Four-bit add with carry in; bit 4 is carry out
   function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
                                          input logic cin);
      nib_add = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction

   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic       sub_cin;

   // ************************************************************
   // Datapath
   // ************************************************************
   // f + ~W + cin: carry out high means no borrow
   always_comb
   begin
      sub_cin = (ain.op == SUB_ACC_FROM_FILE_BORROW) ? ain.cin : 1'b1;
      lo_sum  = nib_add(ain.fval[3:0], ~ain.acc[3:0], sub_cin);
      hi_sum  = nib_add(ain.fval[7:4], ~ain.acc[7:4], lo_sum[4]);
      aout    = '0;
      case (ain.op)
         SUB_ACC_FROM_FILE, SUB_ACC_FROM_FILE_BORROW:
         begin
            aout.res   = {hi_sum[3:0], lo_sum[3:0]};
            aout.c     = hi_sum[4];
            aout.dc    = lo_sum[4];
            aout.wr_c  = 1'b1;
            aout.wr_dc = 1'b1;
            aout.wr_z  = 1'b1;
         end
         NIBBLE_EXCHANGE:
            aout.res = {ain.fval[3:0], ain.fval[7:4]};
         XOR_IMMEDIATE:
         begin
            aout.res  = ain.acc ^ ain.lit;
            aout.wr_z = 1'b1;
         end
         XOR_FILE:
         begin
            aout.res  = ain.acc ^ ain.fval;
            aout.wr_z = 1'b1;
         end
         default:
            aout.res = ain.acc;
      endcase
      aout.z = (aout.res == 8'h00);
   end
endmodule

`default_nettype wire

/* File: ssx_tb_top.sv */
// Purpose: Self-checking bench for the subtract, swap, direction-load and
//          exclusive-OR execution unit, driven over its Avalon-MM slave.
// Assumes: One 100 MHz clock; the slave answers after one wait cycle.
// Notes:   Expected results come from a small bench-side model of the
//          operations, never from the unit's own outputs.
`default_nettype none

module ssx_tb_top
   import ssx_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // Clock, reset and bus signals
   // ************************************************************
   logic        clk;
   logic        nrst;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [7:0]  port_a_direction;
   logic [7:0]  port_b_direction;
   logic [7:0]  port_c_direction;
   int          fails;
   int          tests_run;

   ssx_top dut_u (
      .clk              (clk),
      .nrst             (nrst),
      .avs_address      (avs_address),
      .avs_read         (avs_read),
      .avs_write        (avs_write),
      .avs_writedata    (avs_writedata),
      .avs_readdata     (avs_readdata),
      .avs_waitrequest  (avs_waitrequest),
      .port_a_direction (port_a_direction),
      .port_b_direction (port_b_direction),
      .port_c_direction (port_c_direction)
   );

   // Free-running core clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ************************************************************
   // Bus access and comparison tasks
   // ************************************************************
   task automatic summarize;
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low; bounded wait
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 50)
      begin
         fails++;
         $display("unexpected at %0t: bus access never answered", $time);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // Reference behaviour: returns {result, zero, nibble borrow, carry}
   function automatic logic [10:0] model(input ssx_op_t op, input logic [7:0] a,
                                         input logic [7:0] f, input logic [7:0] k,
                                         input logic [2:0] fl);
      logic [8:0] sub;
      logic [4:0] nib;
      logic [7:0] r;
      logic [2:0] nf;
      logic       bw;
      bw  = (op == SUB_ACC_FROM_FILE_BORROW) ? !fl[0] : 1'b0;
      sub = {1'b0, f} - {1'b0, a} - 9'(bw);
      nib = {1'b0, f[3:0]} - {1'b0, a[3:0]} - 5'(bw);
      nf  = fl;
      r   = a ^ f;
      if (op == SUB_ACC_FROM_FILE || op == SUB_ACC_FROM_FILE_BORROW)
      begin
         r  = sub[7:0];
         nf = {r == 8'h00, !nib[4], !sub[8]};
      end
      else if (op == NIBBLE_EXCHANGE)
         r = {f[3:0], f[7:4]};
      else
      begin
         r = (op == XOR_IMMEDIATE) ? a ^ k : r;
         nf[2] = (r == 8'h00);
      end
      return {r, nf};
   endfunction

   // ************************************************************
   // Stimulus: {op, dest, acc, file, flags, literal} per case
   // ************************************************************
   localparam logic [47:0] CASES [12] = '{
      48'h00_00_05_03_07_00, 48'h00_01_03_03_00_00, 48'h00_00_18_21_07_00,
      48'h01_01_10_10_00_00, 48'h01_00_10_10_01_00, 48'h01_01_ff_ff_06_00,
      48'h02_01_77_a5_05_00, 48'h02_00_11_3c_02_00, 48'h05_00_55_55_03_00,
      48'h05_01_0f_f0_04_00, 48'h04_00_5a_00_03_5a, 48'h04_01_00_00_04_80};

   initial
   begin
      logic [47:0] c;
      logic [10:0] e;
      logic [7:0]  exp_dir [3];
      logic [6:0]  fa;
      logic [7:0]  opnd;
      ssx_op_t     op;
      nrst = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      fails = 0;
      tests_run = 0;
      exp_dir = '{8'hff, 8'hff, 8'hff};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset state, unmapped and write-only reads, read-only ignore
      rd_chk(ADDR_ACC, 32'h0);
      rd_chk(ADDR_FLAGS, 32'h0);
      rd_chk(8'h20, UNMAPPED_RD);
      wr(ADDR_DIR_A, 32'h0);
      rd_chk(ADDR_DIR_A, 32'(DIR_RESET));
      rd_chk(ADDR_INSTR, 32'h0);
      // Every operation except direction load at boundary and flag-flipping values
      for (int i = 0; i < 12; i++)
      begin
         c  = CASES[i];
         op = ssx_op_t'(c[42:40]);
         fa = 7'(i * 37 + 5);
         opnd = (op == XOR_IMMEDIATE) ? c[7:0] : {1'b0, fa};
         wr(ADDR_ACC, 32'(c[31:24]));
         wr(ADDR_FLAGS, 32'(c[15:8]));
         wr(ADDR_FADDR, 32'(fa));
         wr(ADDR_FDATA, 32'(c[23:16]));
         wr(ADDR_INSTR, {16'h0, opnd, 4'h0, c[32], c[42:40]});
         e = model(op, c[31:24], c[23:16], c[7:0], c[10:8]);
         if (c[32] && op != XOR_IMMEDIATE)
         begin
            rd_chk(ADDR_ACC, 32'(c[31:24]));
            rd_chk(ADDR_FDATA, 32'(e[10:3]));
         end
         else
         begin
            rd_chk(ADDR_ACC, 32'(e[10:3]));
            rd_chk(ADDR_FDATA, 32'(c[23:16]));
         end
         rd_chk(ADDR_FLAGS, 32'(e[2:0]));
      end
      // Direction load over operands 4..8; only 5..7 take effect
      for (int n = 4; n < 9; n++)
      begin
         wr(ADDR_ACC, 32'(8'h30 + 8'(n)));
         wr(ADDR_FLAGS, 32'h5);
         wr(ADDR_INSTR, {16'h0, 8'(n), 5'h0, 3'(DIRECTION_LOAD)});
         if (n >= 5 && n <= 7)
            exp_dir[n - 5] = 8'h30 + 8'(n);
         rd_chk(ADDR_FLAGS, 32'h5);
         rd_chk(ADDR_DIR_A, 32'(exp_dir[0]));
         rd_chk(ADDR_DIR_B, 32'(exp_dir[1]));
         rd_chk(ADDR_DIR_C, 32'(exp_dir[2]));
         chk({8'h0, port_a_direction, port_b_direction, port_c_direction},
             {8'h0, exp_dir[0], exp_dir[1], exp_dir[2]});
      end
      // Undefined opcode leaves accumulator and flags alone
      wr(ADDR_ACC, 32'h12);
      wr(ADDR_FLAGS, 32'h2);
      wr(ADDR_INSTR, 32'h0000_0006);
      rd_chk(ADDR_ACC, 32'h12);
      rd_chk(ADDR_FLAGS, 32'h2);
      // Mid-run reset must return every direction register to all inputs
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({8'h0, port_a_direction, port_b_direction, port_c_direction},
          {8'h0, DIR_RESET, DIR_RESET, DIR_RESET});
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(ADDR_DIR_C, 32'(DIR_RESET));
      rd_chk(ADDR_ACC, 32'h0);
      summarize();
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule

`default_nettype wire

/* File: ssx_top.sv */
// Purpose: Execution unit for subtract, borrow subtract, nibble swap,
//          direction load and exclusive-OR, with an Avalon-MM slave.
// Assumes: Single 100 MHz clock; master holds requests until accepted.
// Notes:   Every access takes two cycles: waitrequest falls one cycle
//          after the request, and the access completes at the next edge.
`default_nettype none

// Functional notes
// - Subtract stores file minus accumulator; carry clear when accumulator exceeds file.
// - Subtract clears nibble borrow when accumulator low nibble exceeds file low nibble.
// - File operations write accumulator when destination bit is 0, file when 1.
// - Borrow subtract takes accumulator and inverted carry from file; updates three flags.
// - Nibble swap exchanges file nibbles and leaves every flag untouched.
// - Nibble swap writes file when destination is 1, accumulator when 0.
// - Direction load copies accumulator to port A, B, C for operand 5, 6, 7.
// - Immediate exclusive-OR stores accumulator xor literal; only zero flag changes.
// - File exclusive-OR routes by destination bit; only zero flag changes.
module ssx_top
   import ssx_pkg::*;
(
   input  wire logic        clk,              // Core clock
   input  wire logic        nrst,             // Asynchronous reset, active low
   input  wire logic [7:0]  avs_address,      // Byte address
   input  wire logic        avs_read,         // Read request
   input  wire logic        avs_write,        // Write request
   input  wire logic [31:0] avs_writedata,    // Write data
   output logic      [31:0] avs_readdata,     // Read data
   output logic             avs_waitrequest,  // Stall until low
   output logic      [7:0]  port_a_direction, // Port A direction
   output logic      [7:0]  port_b_direction, // Port B direction
   output logic      [7:0]  port_c_direction  // Port C direction
);
   typedef struct packed {
      logic [7:0]                  acc;
      logic                        c;
      logic                        dc;
      logic                        z;
      logic [6:0]                  faddr;
      logic [FILE_DEPTH-1:0][7:0]  file;
      logic [7:0]                  dir_a;
      logic [7:0]                  dir_b;
      logic [7:0]                  dir_c;
      logic                        waitreq;
      logic [31:0]                 rdata;
   } ssx_state_t;

   ssx_state_t   st_ff;
   ssx_state_t   nxt_st;
   logic [1:0]   rst_sync_ff;
   logic         rst_n;
   logic         exec;
   ssx_op_t      ex_op;
   logic         ex_dst;
   logic [7:0]   ex_opnd;
   ssx_alu_in_t  ain;
   ssx_alu_out_t aout;
   logic [31:0]  rd_mux;

   // ************************************************************
   // Reset release
   // ************************************************************
   // Two stages so release never lands near a clock edge
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst_sync_ff <= 2'b00;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign rst_n = rst_sync_ff[1];

   // ************************************************************
   // Instruction decode and arithmetic
   // ************************************************************
   // Instruction issues on the completing edge of an INSTR write
   assign exec    = avs_write && !avs_read && !st_ff.waitreq && (avs_address == ADDR_INSTR);
   assign ex_op   = ssx_op_t'(avs_writedata[OP_LSB +: 3]);
   assign ex_dst  = avs_writedata[DST_BIT];
   assign ex_opnd = avs_writedata[OPND_LSB +: 8];
   assign ain     = '{op: ex_op, acc: st_ff.acc, fval: st_ff.file[ex_opnd[6:0]],
                      lit: ex_opnd, cin: st_ff.c};

   ssx_alu u_alu
   (
      .ain  (ain),
      .aout (aout)
   );

   // Read mux; unmapped offsets read as zero
   always_comb
   begin
      case (avs_address)
         ADDR_ACC:   rd_mux = {24'h0, st_ff.acc};
         ADDR_FLAGS: rd_mux = {29'h0, st_ff.z, st_ff.dc, st_ff.c};
         ADDR_FADDR: rd_mux = {25'h0, st_ff.faddr};
         ADDR_FDATA: rd_mux = {24'h0, st_ff.file[st_ff.faddr]};
         ADDR_DIR_A: rd_mux = {24'h0, st_ff.dir_a};
         ADDR_DIR_B: rd_mux = {24'h0, st_ff.dir_b};
         ADDR_DIR_C: rd_mux = {24'h0, st_ff.dir_c};
         default:    rd_mux = UNMAPPED_RD;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      nxt_st = st_ff;
      if ((avs_read || avs_write) && st_ff.waitreq)
      begin
         // First cycle: latch read data, drop waitrequest
         nxt_st.waitreq = 1'b0;
         nxt_st.rdata   = rd_mux;
      end
      else
      begin
         nxt_st.waitreq = 1'b1;
         if (avs_write && !avs_read && !st_ff.waitreq)
         begin
            case (avs_address)
               ADDR_ACC:   nxt_st.acc   = avs_writedata[7:0];
               ADDR_FLAGS:
               begin
                  nxt_st.c  = avs_writedata[FLAG_C];
                  nxt_st.dc = avs_writedata[FLAG_DC];
                  nxt_st.z  = avs_writedata[FLAG_Z];
               end
               ADDR_FADDR: nxt_st.faddr = avs_writedata[6:0];
               ADDR_FDATA: nxt_st.file[st_ff.faddr] = avs_writedata[7:0];
               default:    nxt_st.acc   = st_ff.acc; // Read-only, unmapped, or INSTR (handled by exec)
            endcase
         end
      end
      if (exec)
      begin
         // Flags only move where the operation defines them
         if (aout.wr_c)
            nxt_st.c = aout.c;
         if (aout.wr_dc)
            nxt_st.dc = aout.dc;
         if (aout.wr_z)
            nxt_st.z = aout.z;
         if (ssx_is_file_op(ex_op))
         begin
            if (ex_dst)
               nxt_st.file[ex_opnd[6:0]] = aout.res;
            else
               nxt_st.acc = aout.res;
         end
         else if (ex_op == XOR_IMMEDIATE)
            nxt_st.acc = aout.res;
         else if (ex_op == DIRECTION_LOAD)
         begin
            // Operands whose low seven bits fall outside five to seven are dropped silently
            case (ex_opnd[6:0])
               DIR_OPND_A: nxt_st.dir_a = st_ff.acc;
               DIR_OPND_B: nxt_st.dir_b = st_ff.acc;
               DIR_OPND_C: nxt_st.dir_c = st_ff.acc;
               default:    nxt_st.dir_a = st_ff.dir_a;
            endcase
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff         <= '0;
         st_ff.dir_a   <= DIR_RESET;
         st_ff.dir_b   <= DIR_RESET;
         st_ff.dir_c   <= DIR_RESET;
         st_ff.waitreq <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign avs_readdata     = st_ff.rdata;
   assign avs_waitrequest  = st_ff.waitreq;
   assign port_a_direction = st_ff.dir_a;
   assign port_b_direction = st_ff.dir_b;
   assign port_c_direction = st_ff.dir_c;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sub_borrow_a: assert property (exec && ex_op == SUB_ACC_FROM_FILE |=>
      st_ff.c == ($past(st_ff.acc) <= $past(ain.fval)))
      else $error("subtract carry wrong");

   sub_nibble_a: assert property (exec && ex_op == SUB_ACC_FROM_FILE |=>
      st_ff.dc == ($past(st_ff.acc[3:0]) <= $past(ain.fval[3:0])))
      else $error("subtract nibble borrow wrong");

   sub_dest_acc_a: assert property (exec && ex_op == SUB_ACC_FROM_FILE && !ex_dst |=>
      st_ff.acc == 8'($past(ain.fval) - $past(st_ff.acc))
      && st_ff.file == $past(st_ff.file))
      else $error("subtract to accumulator wrong");

   subb_result_a: assert property (exec && ex_op == SUB_ACC_FROM_FILE_BORROW &&
      ex_dst |=> st_ff.file[$past(ex_opnd[6:0])] ==
      8'($past(ain.fval) - $past(st_ff.acc) - {7'h0, !$past(st_ff.c)})
      && st_ff.acc == $past(st_ff.acc))
      else $error("borrow subtract result wrong");

   swap_flags_a: assert property (exec && ex_op == NIBBLE_EXCHANGE |=>
      $stable({st_ff.c, st_ff.dc, st_ff.z})) else $error("swap changed flags");

   swap_file_a: assert property (exec && ex_op == NIBBLE_EXCHANGE && ex_dst |=>
      st_ff.file[$past(ex_opnd[6:0])] == {$past(ain.fval[3:0]), $past(ain.fval[7:4])})
      else $error("swap to file wrong");

   dir_load_a: assert property (exec && ex_op == DIRECTION_LOAD &&
      ex_opnd == 8'h06 |=> port_b_direction == $past(st_ff.acc) && $stable(port_a_direction)
      && $stable(port_c_direction)) else $error("direction load wrong");

   xor_imm_a: assert property (exec && ex_op == XOR_IMMEDIATE |=>
      st_ff.acc == ($past(st_ff.acc) ^ $past(ex_opnd)) && $stable({st_ff.c, st_ff.dc}))
      else $error("immediate xor wrong");

   xor_file_a: assert property (exec && ex_op == XOR_FILE && !ex_dst |=>
      st_ff.acc == ($past(st_ff.acc) ^ $past(ain.fval)) && $stable({st_ff.c, st_ff.dc}))
      else $error("file xor wrong");

   zero_flag_a: assert property (exec && ex_op == XOR_IMMEDIATE |=>
      st_ff.z == (st_ff.acc == 8'h00)) else $error("zero flag wrong");
endmodule

`default_nettype wire
